// ==== rtl/lpss_defines.svh ====
// Constants shared by both ends of the panel power-save link.
`ifndef LPSS_DEFINES_SVH
`define LPSS_DEFINES_SVH
`define LPSS_PCLK_NS 100
`define LPSS_MCLK_NS 100
`define LPSS_BCLK_HALF_LAST 3'h3
`define LPSS_BCLK_PER_CYC 4'h8
`define LPSS_HOLD_CYC (8 * 8 + 12 * ((`LPSS_MCLK_NS + `LPSS_PCLK_NS - 1) / `LPSS_PCLK_NS))
`define LPSS_FRAME_CYCLES 1000
`define LPSS_SEQ_FRAMES 7'h7F
`define LPSS_ICK_FRAMES 8'h80
`define LPSS_LINE_LAST 4'hF
`define LPSS_SAVE_REG 4'h3
`define LPSS_GPIO_REG 4'h5
`define LPSS_GPIO_EN_BIT 4
`define LPSS_SAVE_NORMAL 2'h3
`define LPSS_SAVE_SOFT 2'h0
`define LPSS_APB_CMD 32'h00000000
`define LPSS_APB_WDATA 32'h00000004
`define LPSS_APB_STATUS 32'h00000008
`define LPSS_APB_CFG 32'h0000000C
`define LPSS_CMD_WE_BIT 10
`define LPSS_STAT_LUTBLK_BIT 2
`endif

// ==== rtl/lpss_pkg.sv ====
// Types for the panel power-save sequencer and its host.
package lpss_pkg;
  typedef enum logic [1:0] {
    LPSS_SP_REG = 2'b00,
    LPSS_SP_MEM = 2'b01,
    LPSS_SP_LUT = 2'b10,
    LPSS_SP_RSV = 2'b11
  } lpss_space_e;
  typedef enum logic [1:0] {
    LPSS_SQ_OFF = 2'b00,
    LPSS_SQ_UP = 2'b01,
    LPSS_SQ_ON = 2'b10,
    LPSS_SQ_DN = 2'b11
  } lpss_seq_e;
  typedef enum logic [1:0] {
    LPSS_H_IDLE = 2'b00,
    LPSS_H_REQ = 2'b01,
    LPSS_H_REL = 2'b10
  } lpss_hst_e;
  typedef struct packed {
    logic bclk;
    logic req;
    logic we;
    lpss_space_e space;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic hw_cfg;
    logic hw_pin;
    logic clk_run;
  } lpss_dlink_s;
  typedef struct packed {
    logic rdy;
    logic err;
    logic [7:0] rdata;
  } lpss_hlink_s;
  typedef struct packed {
    lpss_dlink_s s1;
    lpss_dlink_s s2;
    logic bclk_prev;
    logic rdy;
    logic err;
    logic [7:0] rdata;
    logic [15:0][7:0] regs;
    logic [15:0][7:0] palette_table;
    lpss_seq_e seq;
    logic [15:0] fdiv;
    logic [6:0] frames;
    logic pwr;
    logic shift;
    logic line;
    logic frame;
    logic valid;
    logic [11:0] pix;
    logic [3:0] pix_cnt;
    logic [7:0] raddr;
    logic [3:0] gpio_hold;
  } lpss_dev_s;
  typedef struct packed {
    lpss_hst_e st;
    lpss_hlink_s r1;
    lpss_hlink_s r2;
    logic pend;
    logic req;
    logic we;
    lpss_space_e space;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic err;
    logic [7:0] rdata;
    logic lut_blk;
    logic lut_ok;
    logic sw_save;
    logic gate_en;
    logic hw_cfg;
    logic hw_pin;
    logic ick_allow;
    logic [2:0] div;
    logic bclk;
    logic stopped;
    logic [3:0] warm;
    logic [7:0] hold;
    logic [15:0] fcnt;
    logic [7:0] sframes;
    logic ick_run;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lpss_host_s;
endpackage : lpss_pkg

// ==== rtl/lpss_if.sv ====
// Link between the host bus controller and the panel power-save device.
`timescale 1ns/1ps
interface lpss_if;
  logic bclk;
  logic req;
  logic we;
  logic [1:0] space;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic rdy;
  logic err;
  logic [7:0] rdata;
  logic hw_save_cfg;
  logic hw_save_pin;
  logic input_clock_run;
  modport dev_mp (
    input bclk,
    input req,
    input we,
    input space,
    input addr,
    input wdata,
    input hw_save_cfg,
    input hw_save_pin,
    input input_clock_run,
    output rdy,
    output err,
    output rdata
  );
  modport host_mp (
    output bclk,
    output req,
    output we,
    output space,
    output addr,
    output wdata,
    output hw_save_cfg,
    output hw_save_pin,
    output input_clock_run,
    input rdy,
    input err,
    input rdata
  );
endinterface : lpss_if

// ==== rtl/lpss_device.sv ====
// Panel power-save sequencer with its register, memory and palette access gate.
`timescale 1ns/1ps
`include "lpss_defines.svh"
module lpss_device #(
  parameter int FRAME_CYCLES = `LPSS_FRAME_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  lpss_if.dev_mp link,
  output logic panel_power_enable,
  output logic [11:0] panel_pixel_bus,
  output logic panel_shift_clock,
  output logic panel_line_pulse,
  output logic panel_frame_pulse,
  output logic panel_data_valid
);
  localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);
  localparam logic [6:0] SEQ_LAST = `LPSS_SEQ_FRAMES - 7'h01;

  lpss_pkg::lpss_dev_s q;
  lpss_pkg::lpss_dev_s d;
  lpss_pkg::lpss_dlink_s link_in;
  logic [7:0] mem [0:255];
  logic [7:0] mem_rd;
  logic [7:0] mem_ref;
  logic mem_we;
  logic hw_save;
  logic normal;
  logic frame_tick;
  logic refuse;
  logic run;
  logic gpio_en;
  logic [1:0] save_bits;

  // The access fields are bundled behind req, so their skew through the synchroniser is harmless; bclk and the save and clock lines are not.
  assign link_in = {link.bclk, link.req, link.we, lpss_pkg::lpss_space_e'(link.space),
                    link.addr, link.wdata, link.hw_save_cfg, link.hw_save_pin,
                    link.input_clock_run};
  assign mem_rd = mem[q.s2.addr];
  assign mem_ref = mem[q.raddr];

  always_comb begin
    d = q;
    mem_we = 1'b0;
    refuse = 1'b0;
    d.s1 = link_in;
    d.s2 = q.s1;
    d.bclk_prev = q.s2.bclk;
    hw_save = q.s2.hw_cfg & q.s2.hw_pin;
    save_bits = q.regs[`LPSS_SAVE_REG][1:0];
    normal = !hw_save && (save_bits == `LPSS_SAVE_NORMAL);
    gpio_en = q.regs[`LPSS_GPIO_REG][`LPSS_GPIO_EN_BIT];
    frame_tick = (q.fdiv == FRAME_LAST);
    d.fdiv = frame_tick ? 16'h0000 : q.fdiv + 16'h0001;

    // Accesses are taken on a rising edge of the bus clock as seen through the synchroniser.
    if (q.s2.bclk && !q.bclk_prev) begin
      if (q.s2.req && !q.rdy) begin
        refuse = hw_save;
        if (q.s2.space == lpss_pkg::LPSS_SP_LUT && !normal) begin
          refuse = 1'b1;
        end
        if (q.s2.space == lpss_pkg::LPSS_SP_MEM && !q.s2.clk_run) begin
          refuse = 1'b1;
        end
        if (q.s2.space != lpss_pkg::LPSS_SP_MEM && q.s2.addr[7:4] != 4'h0) begin
          refuse = 1'b1;
        end
        if (q.s2.space == lpss_pkg::LPSS_SP_RSV) begin
          refuse = 1'b1;
        end
        d.rdy = 1'b1;
        d.err = refuse;
        d.rdata = 8'h00;
        if (!refuse) begin
          unique case (q.s2.space)
            lpss_pkg::LPSS_SP_REG: begin
              if (q.s2.we) begin
                d.regs[q.s2.addr[3:0]] = q.s2.wdata;
              end else begin
                d.rdata = q.regs[q.s2.addr[3:0]];
              end
            end
            lpss_pkg::LPSS_SP_MEM: begin
              if (q.s2.we) begin
                mem_we = 1'b1;
              end else begin
                d.rdata = mem_rd;
              end
            end
            lpss_pkg::LPSS_SP_LUT: begin
              if (q.s2.we) begin
                d.palette_table[q.s2.addr[3:0]] = q.s2.wdata;
              end else begin
                d.rdata = q.palette_table[q.s2.addr[3:0]];
              end
            end
            lpss_pkg::LPSS_SP_RSV: begin
              d.rdata = 8'h00;
            end
          endcase
        end
      end else if (!q.s2.req && q.rdy) begin
        d.rdy = 1'b0;
      end
    end

    // Power is only ever applied after the signals have run for the full delay.
    unique case (q.seq)
      lpss_pkg::LPSS_SQ_OFF: begin
        if (normal) begin
          d.seq = lpss_pkg::LPSS_SQ_UP;
          d.frames = 7'h00;
        end
      end
      lpss_pkg::LPSS_SQ_UP: begin
        if (!normal) begin
          d.seq = lpss_pkg::LPSS_SQ_OFF;
        end else if (frame_tick) begin
          d.frames = q.frames + 7'h01;
          if (q.frames == SEQ_LAST) begin
            d.seq = lpss_pkg::LPSS_SQ_ON;
          end
        end
      end
      lpss_pkg::LPSS_SQ_ON: begin
        if (!normal) begin
          d.seq = lpss_pkg::LPSS_SQ_DN;
          d.frames = 7'h00;
        end
      end
      lpss_pkg::LPSS_SQ_DN: begin
        if (frame_tick) begin
          d.frames = q.frames + 7'h01;
          if (q.frames == SEQ_LAST) begin
            d.seq = lpss_pkg::LPSS_SQ_OFF;
          end
        end
      end
    endcase
    d.pwr = (d.seq == lpss_pkg::LPSS_SQ_ON);

    // The display runs in every state but off, so the panel sees live signals around power.
    run = (d.seq != lpss_pkg::LPSS_SQ_OFF);
    if (run) begin
      d.shift = !q.shift;
      d.valid = 1'b1;
      d.frame = frame_tick;
      d.gpio_hold = q.regs[`LPSS_GPIO_REG][3:0];
      if (q.shift) begin
        d.pix_cnt = q.pix_cnt + 4'h1;
        d.raddr = q.raddr + 8'h01;
        d.line = (q.pix_cnt == `LPSS_LINE_LAST);
        d.pix = {mem_ref[3:0], mem_ref};
      end
    end else begin
      d.shift = 1'b0;
      d.valid = 1'b0;
      d.frame = 1'b0;
      d.line = 1'b0;
      d.pix = 12'h000;
      d.pix_cnt = 4'h0;
      d.raddr = 8'h00;
    end
    if (gpio_en) begin
      d.pix[11:8] = d.gpio_hold;
    end else if (!run) begin
      d.pix[11:8] = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Display memory has no reset; contents are undefined until written.
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[q.s2.addr] <= q.s2.wdata;
    end
  end

  assign link.rdy = q.rdy;
  assign link.err = q.err;
  assign link.rdata = q.rdata;
  assign panel_power_enable = q.pwr;
  assign panel_pixel_bus = q.pix;
  assign panel_shift_clock = q.shift;
  assign panel_line_pulse = q.line;
  assign panel_frame_pulse = q.frame;
  assign panel_data_valid = q.valid;
endmodule : lpss_device

// ==== rtl/lpss_host.sv ====
// Host bus controller that drives the link and obeys the clock-stopping limits.
`timescale 1ns/1ps
`include "lpss_defines.svh"
module lpss_host #(
  parameter int FRAME_CYCLES = `LPSS_FRAME_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  lpss_if.host_mp link
);
  localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);
  localparam logic [7:0] HOLD_CYC = 8'(`LPSS_HOLD_CYC);

  lpss_pkg::lpss_host_s q;
  lpss_pkg::lpss_host_s d;
  logic tick;
  logic ftick;
  logic stop_ok;
  logic busy;
  logic save_now;
  logic acc;
  logic mapped;

  always_comb begin
    d = q;
    d.r1 = {link.rdy, link.err, link.rdata};
    d.r2 = q.r1;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    d.prdata = 32'h00000000;
    busy = q.pend || (q.st != lpss_pkg::LPSS_H_IDLE);
    tick = (q.div == `LPSS_BCLK_HALF_LAST);
    d.div = tick ? 3'h0 : q.div + 3'h1;
    if (q.hold != 8'h00) begin
      d.hold = q.hold - 8'h01;
    end
    stop_ok = q.gate_en && !q.sw_save && !busy && (q.hold == 8'h00);
    // Stopping and starting only at a half-period boundary keeps every pulse full width.
    if (tick) begin
      if (!q.bclk && stop_ok) begin
        d.stopped = 1'b1;
      end else begin
        d.bclk = !q.bclk;
        d.stopped = 1'b0;
      end
    end
    if (q.stopped) begin
      d.warm = `LPSS_BCLK_PER_CYC;
    end else if (q.warm != 4'h0) begin
      d.warm = q.warm - 4'h1;
    end

    unique case (q.st)
      lpss_pkg::LPSS_H_IDLE: begin
        if (q.pend && !q.stopped && q.warm == 4'h0 && tick && q.bclk) begin
          d.req = 1'b1;
          d.pend = 1'b0;
          d.st = lpss_pkg::LPSS_H_REQ;
          if (q.we && q.space == lpss_pkg::LPSS_SP_REG && q.addr == 8'(`LPSS_SAVE_REG)) begin
            d.lut_ok = (q.wdata[1:0] == `LPSS_SAVE_NORMAL);
            d.sw_save = (q.wdata[1:0] == `LPSS_SAVE_SOFT);
          end
        end
      end
      lpss_pkg::LPSS_H_REQ: begin
        if (q.r2.rdy) begin
          d.req = 1'b0;
          d.err = q.r2.err;
          d.rdata = q.r2.rdata;
          d.st = lpss_pkg::LPSS_H_REL;
        end
      end
      lpss_pkg::LPSS_H_REL: begin
        if (!q.r2.rdy) begin
          d.st = lpss_pkg::LPSS_H_IDLE;
          d.hold = HOLD_CYC;
        end
      end
      default: begin
        d.st = lpss_pkg::LPSS_H_IDLE;
      end
    endcase

    // The input clock may stop only once the save state has lasted the full frame count.
    save_now = q.sw_save || (q.hw_cfg && q.hw_pin);
    ftick = (q.fcnt == FRAME_LAST);
    d.fcnt = ftick ? 16'h0000 : q.fcnt + 16'h0001;
    if (!save_now) begin
      d.sframes = 8'h00;
    end else if (ftick && q.sframes != `LPSS_ICK_FRAMES) begin
      d.sframes = q.sframes + 8'h01;
    end
    d.ick_run = !(q.ick_allow && save_now && q.sframes == `LPSS_ICK_FRAMES);

    acc = psel && penable;
    mapped = (paddr == `LPSS_APB_CMD) || (paddr == `LPSS_APB_WDATA) ||
             (paddr == `LPSS_APB_STATUS) || (paddr == `LPSS_APB_CFG);
    if (acc && !q.pready) begin
      d.pready = 1'b1;
      d.pslverr = !mapped || (pwrite && paddr == `LPSS_APB_CMD && busy);
      if (!pwrite) begin
        if (paddr == `LPSS_APB_CMD) begin
          d.prdata = {21'h000000, q.we, q.space, q.addr};
        end else if (paddr == `LPSS_APB_WDATA) begin
          d.prdata = {24'h000000, q.wdata};
        end else if (paddr == `LPSS_APB_STATUS) begin
          d.prdata = {16'h0000, q.rdata, 3'h0, q.ick_run, !q.stopped, q.lut_blk, q.err, busy};
        end else if (paddr == `LPSS_APB_CFG) begin
          d.prdata = {28'h0000000, q.ick_allow, q.hw_pin, q.hw_cfg, q.gate_en};
        end
      end
    end
    if (acc && q.pready && pwrite && !q.pslverr) begin
      if (paddr == `LPSS_APB_CMD) begin
        if (pwdata[`LPSS_CMD_WE_BIT] && pwdata[9:8] == 2'b10 && !q.lut_ok) begin
          d.lut_blk = 1'b1;
        end else begin
          d.pend = 1'b1;
          d.we = pwdata[`LPSS_CMD_WE_BIT];
          d.space = lpss_pkg::lpss_space_e'(pwdata[9:8]);
          d.addr = pwdata[7:0];
        end
      end else if (paddr == `LPSS_APB_WDATA) begin
        d.wdata = pwdata[7:0];
      end else if (paddr == `LPSS_APB_STATUS) begin
        if (pwdata[`LPSS_STAT_LUTBLK_BIT]) begin
          d.lut_blk = 1'b0;
        end
      end else if (paddr == `LPSS_APB_CFG) begin
        d.gate_en = pwdata[0];
        d.hw_cfg = pwdata[1];
        d.hw_pin = pwdata[2];
        d.ick_allow = pwdata[3];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.sw_save <= 1'b1;
      q.ick_run <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign link.bclk = q.bclk;
  assign link.req = q.req;
  assign link.we = q.we;
  assign link.space = q.space;
  assign link.addr = q.addr;
  assign link.wdata = q.wdata;
  assign link.hw_save_cfg = q.hw_cfg;
  assign link.hw_save_pin = q.hw_pin;
  assign link.input_clock_run = q.ick_run;
endmodule : lpss_host

// ==== testbench/lpss_props.sv ====
// Link and panel checks for the power-save sequencer pair.
`timescale 1ns/1ps
`include "lpss_defines.svh"
module lpss_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bclk,
  input wire logic req,
  input wire logic we,
  input wire logic [1:0] space,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rdy,
  input wire logic err,
  input wire logic hw_save_cfg,
  input wire logic hw_save_pin,
  input wire logic panel_power_enable,
  input wire logic [11:0] panel_pixel_bus,
  input wire logic panel_shift_clock,
  input wire logic panel_line_pulse,
  input wire logic panel_frame_pulse,
  input wire logic panel_data_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] hold_q;
  logic [2:0] low_q;
  // A low run longer than a half period means the bus clock has been stopped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 8'h00;
      low_q <= 3'h0;
    end else begin
      if ($fell(rdy)) begin
        hold_q <= 8'(`LPSS_HOLD_CYC);
      end else if (hold_q != 8'h00) begin
        hold_q <= hold_q - 8'h01;
      end
      low_q <= bclk ? 3'h0 : ((low_q == 3'h7) ? low_q : low_q + 3'h1);
    end
  end
  hw_save_a: assert property ($rose(rdy) && hw_save_cfg && hw_save_pin |-> err)
    else $error("access not refused in hardware save");
  pins_low_a: assert property (!panel_data_valid |-> !panel_shift_clock && !panel_line_pulse
    && !panel_frame_pulse && panel_pixel_bus[7:0] == 8'h00)
    else $error("panel outputs not low while display is off");
  power_up_a: assert property ($rose(panel_power_enable) |-> $past(panel_data_valid, 8))
    else $error("panel power rose before signals ran");
  power_dn_a: assert property ($fell(panel_data_valid) |-> !$past(panel_power_enable))
    else $error("panel signals stopped before power dropped");
  bclk_high_a: assert property ($rose(bclk) |-> bclk [*4] ##1 !bclk)
    else $error("bus clock high phase wrong or stopped high");
  bclk_hold_a: assert property (low_q > 3'h4 |-> hold_q == 8'h00)
    else $error("bus clock stopped too soon after access");
  req_warm_a: assert property ($rose(req) |-> $past(bclk) || $past(bclk, 2)
    || $past(bclk, 3) || $past(bclk, 4))
    else $error("request without running bus clock");
  req_fields_a: assert property (req && $past(req) |-> $stable(we) && $stable(space)
    && $stable(addr) && $stable(wdata))
    else $error("request fields changed while pending");
  req_drop_a: assert property ($fell(req) |-> rdy)
    else $error("request dropped before ready");
  rdy_bound_a: assert property ($rose(req) |-> ##[1:40] rdy)
    else $error("no ready in time");
endmodule : lpss_props

// ==== testbench/testbench.sv ====
// Self-checking bench for the host controller and power-save device pair.
`timescale 1ns/1ps
`include "lpss_defines.svh"
module testbench;
  localparam int FC = 20;
  localparam int SEQ = 127 * FC;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic pwr, shf, lin, frm, vld;
  logic [11:0] pix;
  int mismatches, n_compared, n;
  lpss_if lk();
  lpss_host #(.FRAME_CYCLES(FC)) i_lpss_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(lk));
  lpss_device #(.FRAME_CYCLES(FC)) i_lpss_device (.pclk(pclk), .presetn(presetn), .link(lk),
    .panel_power_enable(pwr), .panel_pixel_bus(pix), .panel_shift_clock(shf),
    .panel_line_pulse(lin), .panel_frame_pulse(frm), .panel_data_valid(vld));
  lpss_props chk_props (.pclk(pclk), .presetn(presetn), .bclk(lk.bclk), .req(lk.req),
    .we(lk.we), .space(lk.space), .addr(lk.addr), .wdata(lk.wdata), .rdy(lk.rdy),
    .err(lk.err), .hw_save_cfg(lk.hw_save_cfg), .hw_save_pin(lk.hw_save_pin),
    .panel_power_enable(pwr), .panel_pixel_bus(pix), .panel_shift_clock(shf),
    .panel_line_pulse(lin), .panel_frame_pulse(frm), .panel_data_valid(vld));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Entered just after a rising edge; leaves one idle edge so strobes never double up.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("mismatch at %0t: bus answer timed out", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // One link access through the command registers; rd ends as the status word.
  task automatic op(input logic [1:0] sp, input logic w, input logic [7:0] a,
    input logic [7:0] d);
    int k;
    k = 0;
    apb(1'b1, `LPSS_APB_WDATA, {24'h000000, d});
    apb(1'b1, `LPSS_APB_CMD, {21'h000000, w, sp, a});
    do begin
      apb(1'b0, `LPSS_APB_STATUS, 32'h00000000);
      k++;
    end while (rd[0] !== 1'b0 && k < 100);
    if (rd[0] !== 1'b0) begin
      mismatches++;
      $display("mismatch at %0t: link access timed out", $time);
    end
  endtask : op
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_lvl
  task automatic t_reset;
    chk({pwr, vld, shf, lin, frm, pix}, 32'h00000000);
    apb(1'b0, 32'h00000010, 32'h00000000);
    chk(er, 1'b1);
    op(2'h2, 1'b1, 8'h00, 8'h55);
    chk(rd[2], 1'b1);
    apb(1'b1, `LPSS_APB_STATUS, 32'h00000004);
    apb(1'b0, `LPSS_APB_STATUS, 32'h00000000);
    chk(rd[2], 1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_up;
    op(2'h0, 1'b1, 8'h03, 8'h03);
    chk(rd[1], 1'b0);
    wait_lvl(vld, 1'b1, 40);
    chk(vld, 1'b1);
    chk(pwr, 1'b0);
    wait_lvl(pwr, 1'b1, SEQ + 4 * FC);
    chk(n >= SEQ - 2 * FC && n <= SEQ + FC, 1'b1);
    wait_lvl(frm, 1'b1, FC + 2);
    chk(frm, 1'b1);
    wait_lvl(lin, 1'b1, 40);
    chk(lin, 1'b1);
    op(2'h2, 1'b1, 8'h04, 8'hA5);
    chk(rd[2:1], 2'h0);
    op(2'h2, 1'b0, 8'h04, 8'h00);
    chk(rd[15:8], 8'hA5);
    op(2'h1, 1'b1, 8'h80, 8'h3C);
    op(2'h0, 1'b1, 8'h05, 8'h1A);
    repeat (4) @(posedge pclk);
    chk(pix[11:8], 4'hA);
    $display("test power up done");
  endtask : t_up
  task automatic t_soft;
    op(2'h0, 1'b1, 8'h03, 8'h00);
    chk({pwr, vld}, 2'h1);
    wait_lvl(vld, 1'b0, SEQ + 4 * FC);
    chk(n >= SEQ - 3 * FC && n <= SEQ + FC, 1'b1);
    chk({pwr, shf, lin, frm, pix[7:0]}, 32'h00000000);
    chk(pix[11:8], 4'hA);
    op(2'h0, 1'b0, 8'h05, 8'h00);
    chk(rd[15:8], 8'h1A);
    op(2'h1, 1'b0, 8'h80, 8'h00);
    chk(rd[15:8], 8'h3C);
    // Both reserved codes, then 00 last, so the host ends in soft save for the clock test.
    for (int c = 2; c >= 0; c--) begin
      op(2'h0, 1'b1, 8'h03, 8'(c));
      op(2'h2, 1'b0, 8'h04, 8'h00);
      chk(rd[1], 1'b1);
      chk(pwr, 1'b0);
    end
    $display("test soft save done");
  endtask : t_soft
  task automatic t_clocks;
    apb(1'b1, `LPSS_APB_CFG, 32'h00000008);
    repeat (130 * FC) @(posedge pclk);
    apb(1'b0, `LPSS_APB_STATUS, 32'h00000000);
    chk(rd[4], 1'b0);
    op(2'h1, 1'b0, 8'h80, 8'h00);
    chk(rd[1], 1'b1);
    op(2'h0, 1'b0, 8'h05, 8'h00);
    chk(rd[1], 1'b0);
    apb(1'b1, `LPSS_APB_CFG, 32'h00000001);
    op(2'h0, 1'b1, 8'h03, 8'h03);
    wait_lvl(pwr, 1'b1, SEQ + 4 * FC);
    chk(pwr, 1'b1);
    repeat (120) @(posedge pclk);
    apb(1'b0, `LPSS_APB_STATUS, 32'h00000000);
    chk(rd[3], 1'b0);
    op(2'h0, 1'b0, 8'h03, 8'h00);
    chk(rd[15:8], 8'h03);
    $display("test clocks done");
  endtask : t_clocks
  task automatic t_hw;
    apb(1'b1, `LPSS_APB_CFG, 32'h00000007);
    for (int s = 0; s < 3; s++) begin
      op(2'(s), 1'b0, 8'h04, 8'h00);
      chk(rd[1], 1'b1);
    end
    chk(pwr, 1'b0);
    wait_lvl(vld, 1'b0, SEQ + 4 * FC);
    chk({vld, shf, pix[7:0]}, 10'h000);
    apb(1'b1, `LPSS_APB_CFG, 32'h0000000F);
    repeat (130 * FC) @(posedge pclk);
    apb(1'b0, `LPSS_APB_STATUS, 32'h00000000);
    chk(rd[4], 1'b0);
    $display("test hardware save done");
  endtask : t_hw
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    end_of_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    mismatches = 0;
    n_compared = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_up();
    t_soft();
    t_clocks();
    t_hw();
    end_of_test();
  end
endmodule : testbench
